/* core/pcgpio_press_timer.v */
// Push button press timer: short, medium and long press detection
// Assumes the button input is already synchronised, high while pressed
`default_nettype none
`include "pcgpio_consts.vh"
module pcgpio_press_timer #(
  parameter MS_CYC = `PCG_MS_CYC
) (
  input wire clock,
  input wire nrst,
  input wire pressed,
  input wire [1:0] hold_sel,
  output reg short_pulse,
  output reg medium_pulse,
  output reg long_pulse
);
  reg [31:0] ms_cnt_reg;
  reg [15:0] held_ms_reg;
  reg pressed_d_reg;
  reg long_done_reg;
  wire ms_tick;
  wire [15:0] med_ms;
  wire [31:0] med_full;
  assign ms_tick = (ms_cnt_reg == MS_CYC - 1);
  // Medium hold in ms: base seconds plus selection, cut to counter width
  assign med_full = (`PCG_MED_BASE_S + {30'h00000000, hold_sel}) * 1000;
  assign med_ms = med_full[15:0];
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ms_cnt_reg <= 32'h00000000;
      held_ms_reg <= 16'h0000;
      pressed_d_reg <= 1'b0;
      long_done_reg <= 1'b0;
      short_pulse <= 1'b0;
      medium_pulse <= 1'b0;
      long_pulse <= 1'b0;
    end else begin
      pressed_d_reg <= pressed;
      short_pulse <= 1'b0;
      medium_pulse <= 1'b0;
      long_pulse <= 1'b0;
      if (pressed) begin
        ms_cnt_reg <= ms_tick ? 32'h00000000 : ms_cnt_reg + 32'h00000001;
        if (ms_tick && held_ms_reg != 16'hFFFF)
          held_ms_reg <= held_ms_reg + 16'h0001;
        if (!long_done_reg && held_ms_reg >= `PCG_LONG_S * 1000) begin
          long_pulse <= 1'b1;
          long_done_reg <= 1'b1;
        end
      end else begin
        ms_cnt_reg <= 32'h00000000;
        held_ms_reg <= 16'h0000;
        long_done_reg <= 1'b0;
        if (pressed_d_reg && !long_done_reg) begin
          if (held_ms_reg >= med_ms)
            medium_pulse <= 1'b1;
          else if (held_ms_reg > `PCG_SHORT_MS)
            short_pulse <= 1'b1;
        end
      end
    end
  end
endmodule // pcgpio_press_timer
`default_nettype wire

/* core/pcgpio_top.v */
// Power controller states, boot sequencing and ten shared pins
// Assumes inputs synchronous to a 25 MHz clock; reset comes from power-on
`default_nettype none
`include "pcgpio_consts.vh"
module pcgpio_top #(
  parameter PROC_RST_CYC = `PCG_PROC_RST_CYC,
  parameter MS_CYC = `PCG_MS_CYC
) (
  input wire clock,
  input wire nrst,
  input wire switch_detect_in,
  input wire adapter_in,
  input wire ext_wake_irq,
  input wire external_program_present,
  input wire seq_done,
  input wire seq_irq_clear,
  input wire sys_reset_drive,
  input wire [1:0] hold_sel,
  input wire status_clr_short,
  input wire status_clr_medium,
  input wire [10:1] gpio_off,
  input wire [10:1] gpio_func,
  input wire [10:1] special_out,
  input wire [10:1] gpio_dir,
  input wire [10:1] gpio_out_mode,
  input wire [10:1] gpio_in_mode,
  input wire [10:1] gpio_both_edges,
  input wire [10:1] gpio_int_edge,
  input wire [10:1] gpio_int_en,
  input wire data_wr,
  input wire [10:1] data_wdata,
  input wire int_stat_wr,
  input wire [10:1] int_stat_wdata,
  input wire [10:1] pin_in,
  output reg [10:1] pin_out,
  output reg [10:1] pin_oe,
  output reg [10:1] gpio_data,
  output reg [10:1] gpio_int_status,
  output reg gpio_irq,
  output reg power_state_on_bit,
  output reg clock_generator,
  output reg processor_supply,
  output reg processor_rst_n,
  output reg boot_from_external,
  output reg wake_irq_pending,
  output reg cpu_sleep,
  output reg sys_reset_n_out,
  output reg sys_reset_n_oe,
  output reg short_status,
  output reg medium_status
);
  localparam S_OFF = 4'b0001;
  localparam S_PWRUP = 4'b0010;
  localparam S_RUN = 4'b0100;
  localparam S_SLEEP = 4'b1000;
  reg [3:0] state_reg;
  reg [31:0] rst_cnt_reg;
  reg [10:1] pin_s1_reg;
  reg [10:1] pin_s2_reg;
  reg [10:1] pin_prev_reg;
  reg sw_s1_reg;
  reg sw_s2_reg;
  wire sw_short;
  wire sw_medium;
  wire sw_long;
  wire [10:1] rise;
  wire [10:1] fall;
  wire [10:1] is_out;
  wire [10:1] int_edge;
  wire [10:1] data_edge;
  wire [10:1] od_mode;
  reg [1:0] warm_reg;
  wire warm;
  // Input synchronisers
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_s1_reg <= 10'h000;
      pin_s2_reg <= 10'h000;
      pin_prev_reg <= 10'h000;
      sw_s1_reg <= 1'b0;
      sw_s2_reg <= 1'b0;
      warm_reg <= 2'h0;
    end else begin
      if (warm_reg != 2'h3)
        warm_reg <= warm_reg + 2'h1;
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
      sw_s1_reg <= switch_detect_in;
      sw_s2_reg <= sw_s1_reg;
    end
  end
  pcgpio_press_timer #(
    .MS_CYC(MS_CYC)
  ) u_press (
    .clock(clock),
    .nrst(nrst),
    .pressed(sw_s2_reg),
    .hold_sel(hold_sel),
    .short_pulse(sw_short),
    .medium_pulse(sw_medium),
    .long_pulse(sw_long)
  );
  // No edges until both sync stages and the history flop hold real levels
  assign warm = (warm_reg == 2'h3);
  assign rise = pin_s2_reg & ~pin_prev_reg & {10{warm}};
  assign fall = ~pin_s2_reg & pin_prev_reg & {10{warm}};
  // Pin is an output only in general purpose mode without special function
  assign is_out = ~gpio_off & ~gpio_func & gpio_dir;
  assign int_edge = (rise & ~gpio_int_edge) | (fall & gpio_int_edge);
  assign data_edge = rise | (fall & gpio_both_edges);
  assign od_mode = gpio_out_mode | `PCG_OD_ONLY_MASK;
  // Power state machine
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_OFF;
      rst_cnt_reg <= 32'h00000000;
      power_state_on_bit <= 1'b0;
      clock_generator <= 1'b0;
      processor_supply <= 1'b0;
      processor_rst_n <= 1'b0;
      boot_from_external <= 1'b0;
      wake_irq_pending <= 1'b0;
      cpu_sleep <= 1'b0;
      sys_reset_n_out <= 1'b0;
      sys_reset_n_oe <= 1'b1;
    end else begin
      sys_reset_n_out <= 1'b0;
      sys_reset_n_oe <= sys_reset_drive | sw_long;
      case (state_reg)
        S_OFF: begin
          power_state_on_bit <= 1'b0;
          clock_generator <= 1'b0;
          processor_supply <= 1'b0;
          processor_rst_n <= 1'b0;
          cpu_sleep <= 1'b0;
          if (sw_short || adapter_in || ext_wake_irq) begin
            wake_irq_pending <= 1'b1;
            power_state_on_bit <= 1'b1;
            clock_generator <= 1'b1;
            processor_supply <= 1'b1;
            rst_cnt_reg <= 32'h00000000;
            state_reg <= S_PWRUP;
          end
        end
        S_PWRUP: begin
          if (rst_cnt_reg >= PROC_RST_CYC - 1) begin
            processor_rst_n <= 1'b1;
            boot_from_external <= external_program_present;
            state_reg <= S_RUN;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + 32'h00000001;
          end
        end
        S_RUN: begin
          cpu_sleep <= 1'b0;
          if (seq_done) begin
            cpu_sleep <= 1'b1;
            state_reg <= S_SLEEP;
          end
        end
        S_SLEEP: begin
          if (wake_irq_pending || sw_short || sw_medium || adapter_in ||
              ext_wake_irq) begin
            cpu_sleep <= 1'b0;
            state_reg <= S_RUN;
          end
        end
        default: state_reg <= S_OFF;
      endcase
      // New wake event wins over a clear in the same cycle
      if (state_reg != S_OFF) begin
        if (sw_short || adapter_in || ext_wake_irq)
          wake_irq_pending <= 1'b1;
        else if (seq_irq_clear)
          wake_irq_pending <= 1'b0;
      end
      if (sw_long) begin
        state_reg <= S_OFF;
        wake_irq_pending <= 1'b0;
        power_state_on_bit <= 1'b0;
        processor_rst_n <= 1'b0;
      end
    end
  end
  // Switch status bits, set wins over clear
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      short_status <= 1'b0;
      medium_status <= 1'b0;
    end else begin
      if (sw_short)
        short_status <= 1'b1;
      else if (status_clr_short)
        short_status <= 1'b0;
      if (sw_medium)
        medium_status <= 1'b1;
      else if (status_clr_medium)
        medium_status <= 1'b0;
    end
  end
  // Per-pin data, interrupt status and pin drive
  genvar i;
  generate
    for (i = 1; i <= `PCG_NPINS; i = i + 1) begin : g_pin
      always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          gpio_data[i] <= 1'b0;
          gpio_int_status[i] <= 1'b0;
          pin_out[i] <= 1'b0;
          pin_oe[i] <= 1'b0;
        end else begin
          if (is_out[i]) begin
            if (data_wr)
              gpio_data[i] <= data_wdata[i];
          end else if (!gpio_in_mode[i]) begin
            gpio_data[i] <= pin_s2_reg[i];
          end else if (data_edge[i]) begin
            gpio_data[i] <= 1'b1;
          end else if (data_wr && !data_wdata[i]) begin
            gpio_data[i] <= 1'b0;
          end
          if (!is_out[i] && !gpio_off[i] && int_edge[i])
            gpio_int_status[i] <= 1'b1;
          else if (int_stat_wr && int_stat_wdata[i])
            gpio_int_status[i] <= 1'b0;
          if (gpio_off[i]) begin
            pin_out[i] <= 1'b0;
            pin_oe[i] <= 1'b0;
          end else if (gpio_func[i]) begin
            pin_out[i] <= special_out[i];
            pin_oe[i] <= od_mode[i] ? !special_out[i] : 1'b1;
          end else if (is_out[i]) begin
            pin_out[i] <= gpio_data[i];
            pin_oe[i] <= od_mode[i] ? !gpio_data[i] : 1'b1;
          end else begin
            pin_out[i] <= 1'b0;
            pin_oe[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      gpio_irq <= 1'b0;
    else
      gpio_irq <= |(gpio_int_status & gpio_int_en);
  end
endmodule // pcgpio_top
`default_nettype wire

/* pkg/pcgpio_consts.vh */
// Constants for the power control and general purpose pin block
// Assumes a 25 MHz clock and a single active-low asynchronous reset
`ifndef PCGPIO_CONSTS_VH
`define PCGPIO_CONSTS_VH
`define PCG_CLK_HZ 25000000
`define PCG_NPINS 10
`define PCG_PROC_RST_MS 4
`define PCG_PROC_RST_CYC (`PCG_CLK_HZ / 1000 * `PCG_PROC_RST_MS)
`define PCG_SHORT_MS 100
`define PCG_SHORT_CYC (`PCG_CLK_HZ / 1000 * `PCG_SHORT_MS)
`define PCG_MS_CYC (`PCG_CLK_HZ / 1000)
`define PCG_LONG_S 15
`define PCG_MED_BASE_S 2
`define PCG_HOLD_SEL_RST 2'h0
`define PCG_OD_ONLY_MASK 10'h017
`define PCG_CFG_RST 10'h000
`endif

/* verif/pcgpio_pin_env.sv */
// Far side of the pins: pull-ups plus optional external drivers
// Assumes pin_oe high means the block drives pin_out
`default_nettype none
module pcgpio_pin_env (
  input wire logic [10:1] pin_out,
  input wire logic [10:1] pin_oe,
  input wire logic [10:1] ext_val,
  input wire logic [10:1] ext_en,
  output logic [10:1] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Block drive first, then external drive, else the pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en);
endmodule // pcgpio_pin_env
`default_nettype wire

/* verif/pcgpio_props.sv */
// Checker on the top ports of the power control and pin block
// Assumes binding into pcgpio_top built with short sim counts
`default_nettype none
module pcgpio_props (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sys_reset_drive,
  input wire logic status_clr_short,
  input wire logic int_stat_wr,
  input wire logic external_program_present,
  input wire logic [10:1] gpio_off,
  input wire logic [10:1] gpio_int_en,
  input wire logic [10:1] int_stat_wdata,
  input wire logic [10:1] pin_out,
  input wire logic [10:1] pin_oe,
  input wire logic [10:1] gpio_int_status,
  input wire logic gpio_irq,
  input wire logic power_state_on_bit,
  input wire logic clock_generator,
  input wire logic processor_supply,
  input wire logic processor_rst_n,
  input wire logic boot_from_external,
  input wire logic sys_reset_n_out,
  input wire logic sys_reset_n_oe,
  input wire logic short_status
);
  timeunit 1ns;
  timeprecision 1ns;
  logic up_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Marks edges after the first one out of reset
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      up_reg <= 1'b0;
    else
      up_reg <= 1'b1;
  end
  property p_od; (pin_oe & pin_out & 10'h017) == 10'h000; endproperty
  a_od: assert property (p_od) else $error("drain-only pin high");
  property p_srst;
    up_reg |-> !sys_reset_n_out && sys_reset_n_oe == $past(sys_reset_drive);
  endproperty
  a_srst: assert property (p_srst) else $error("system reset pin");
  property p_irq;
    up_reg |-> gpio_irq == |$past(gpio_int_status & gpio_int_en);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not status and en");
  property p_wclr;
    up_reg |-> ($past(gpio_int_status) & ~gpio_int_status
      & ~($past(int_stat_wdata) & {10{$past(int_stat_wr)}})) == 10'h000;
  endproperty
  a_wclr: assert property (p_wclr) else $error("status lost");
  property p_wake;
    $rose(power_state_on_bit) |-> clock_generator && processor_supply;
  endproperty
  a_wake: assert property (p_wake) else $error("clock power off");
  property p_rel;
    $rose(power_state_on_bit) |-> !processor_rst_n[*8] ##[1:30] processor_rst_n;
  endproperty
  a_rel: assert property (p_rel) else $error("cpu reset timing");
  property p_boot;
    $rose(processor_rst_n) |->
      boot_from_external == $past(external_program_present);
  endproperty
  a_boot: assert property (p_boot) else $error("boot source");
  property p_sclr; $fell(short_status) |-> $past(status_clr_short); endproperty
  a_sclr: assert property (p_sclr) else $error("short status lost");
  property p_off; up_reg |-> (pin_oe & $past(gpio_off)) == 10'h000; endproperty
  a_off: assert property (p_off) else $error("shared pin driven");
endmodule // pcgpio_props
bind pcgpio_top pcgpio_props u_props (.*);
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the power control and pin block
// Assumes the design include path and short sim counts
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [10:1] off, func, spec, dir, od, dat, oe;
  } pcgpio_row_t;
  logic clock, nrst, switch_detect_in, adapter_in, ext_wake_irq;
  logic external_program_present, seq_done, seq_irq_clear, sys_reset_drive;
  logic [1:0] hold_sel;
  logic status_clr_short, status_clr_medium, data_wr, int_stat_wr;
  logic [10:1] gpio_off, gpio_func, special_out, gpio_dir, gpio_out_mode;
  logic [10:1] gpio_in_mode, gpio_both_edges, gpio_int_edge, gpio_int_en;
  logic [10:1] data_wdata, int_stat_wdata, pin_in, pin_out, pin_oe;
  logic [10:1] gpio_data, gpio_int_status, ext_val, ext_en;
  logic gpio_irq, power_state_on_bit, clock_generator, processor_supply;
  logic processor_rst_n, boot_from_external, wake_irq_pending, cpu_sleep;
  logic sys_reset_n_out, sys_reset_n_oe, short_status, medium_status;
  int err_total, comparisons;
  pcgpio_row_t rows [4] = '{
    '{10'h000, 10'h000, 10'h000, 10'h3FF, 10'h000, 10'h155, 10'h3EA},
    '{10'h000, 10'h000, 10'h000, 10'h3FF, 10'h3FF, 10'h0F0, 10'h30F},
    '{10'h3FF, 10'h000, 10'h000, 10'h3FF, 10'h000, 10'h3FF, 10'h000},
    '{10'h000, 10'h3FF, 10'h3E8, 10'h000, 10'h000, 10'h3E8, 10'h3FF}};
  pcgpio_top #(.PROC_RST_CYC(20), .MS_CYC(4)) u_dut (.*);
  pcgpio_pin_env u_env (.*);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [10:1] got, input logic [10:1] exp);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Data write (s=0) or status clear write (s=1), one cycle pulse
  task automatic wr(input logic s, input logic [10:1] d);
    data_wdata = d;
    int_stat_wdata = d;
    data_wr = !s;
    int_stat_wr = s;
    cyc(1);
    {data_wr, int_stat_wr} = 2'h0;
  endtask
  task automatic press(input int n);
    switch_detect_in = 1'b1;
    cyc(n);
    switch_detect_in = 1'b0;
  endtask
  // Bounded wait: 0 short, 1 medium, 2 processor reset released
  task automatic await(input int sel, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      if ((sel == 0 && short_status) || (sel == 1 && medium_status)
          || (sel == 2 && processor_rst_n))
        break;
      cyc(1);
    end
    if (k == lim) begin
      err_total++;
      conclude();
    end
  endtask
  initial begin
    {nrst, switch_detect_in, adapter_in, ext_wake_irq, seq_done} = 5'h00;
    {seq_irq_clear, sys_reset_drive, status_clr_short} = 3'h0;
    {status_clr_medium, data_wr, int_stat_wr, hold_sel} = 5'h00;
    {gpio_off, gpio_func, special_out, gpio_dir, gpio_out_mode} = '0;
    {gpio_in_mode, gpio_both_edges, gpio_int_edge, gpio_int_en} = '0;
    {data_wdata, int_stat_wdata, ext_val, ext_en} = '0;
    external_program_present = 1'b1;
    err_total = 0;
    comparisons = 0;
    cyc(5);
    chk({8'h00, sys_reset_n_oe, power_state_on_bit}, 10'h002);
    nrst = 1'b1;
    cyc(2);
    foreach (rows[i]) begin
      {gpio_off, gpio_func, special_out, gpio_dir, gpio_out_mode} =
        rows[i][69:20];
      wr(1'b0, rows[i].dat);
      cyc(4);
      chk(pin_in, rows[i].dat);
      chk(pin_oe, rows[i].oe);
      if (rows[i].func === 10'h000)
        chk(gpio_data, rows[i].dat);
    end
    {gpio_off, gpio_func, gpio_dir} = '0;
    ext_en = 10'h3FF;
    ext_val = 10'h1C3;
    cyc(4);
    chk(gpio_data, 10'h1C3);
    wr(1'b0, 10'h000);
    cyc(2);
    chk(gpio_data, 10'h1C3);
    ext_val = 10'h000;
    {gpio_in_mode, gpio_both_edges} = {10'h3FF, 10'h001};
    {gpio_int_edge, gpio_int_en} = {10'h002, 10'h001};
    cyc(4);
    wr(1'b1, 10'h3FF);
    wr(1'b0, 10'h000);
    cyc(2);
    chk(gpio_int_status | gpio_data, 10'h000);
    ext_val = 10'h3FF;
    cyc(6);
    chk(gpio_data, 10'h3FF);
    chk(gpio_int_status, 10'h3FD);
    chk({9'h000, gpio_irq}, 10'h001);
    ext_val = 10'h000;
    wr(1'b0, 10'h3FF);
    cyc(6);
    chk(gpio_data, 10'h3FF);
    chk(gpio_int_status, 10'h3FF);
    wr(1'b1, 10'h3FE);
    cyc(2);
    chk({gpio_int_status[10:2], gpio_irq}, 10'h001);
    gpio_int_en = 10'h000;
    cyc(2);
    chk({gpio_int_status[10:2], gpio_irq}, 10'h000);
    wr(1'b0, 10'h000);
    cyc(2);
    chk(gpio_data, 10'h000);
    sys_reset_drive = 1'b1;
    press(500);
    await(0, 30);
    chk({8'h00, short_status, medium_status}, 10'h002);
    chk({9'h000, power_state_on_bit}, 10'h001);
    await(2, 40);
    chk({8'h00, boot_from_external, sys_reset_n_oe}, 10'h003);
    {sys_reset_drive, seq_done, seq_irq_clear} = 3'h3;
    cyc(1);
    {seq_done, seq_irq_clear} = 2'h0;
    cyc(2);
    chk({7'h00, cpu_sleep, wake_irq_pending, sys_reset_n_oe}, 10'h004);
    hold_sel = 2'h1;
    status_clr_short = 1'b1;
    cyc(1);
    status_clr_short = 1'b0;
    press(9000);
    await(0, 30);
    chk({8'h00, short_status, medium_status}, 10'h002);
    status_clr_short = 1'b1;
    cyc(1);
    status_clr_short = 1'b0;
    press(12100);
    await(1, 30);
    chk({8'h00, short_status, medium_status}, 10'h001);
    conclude();
  end
endmodule // tb
`default_nettype wire
